// [trpc_pkg.sv]
package trpc_pkg;

   // ****************************************
   // field widths
   // ****************************************
   localparam int VOD_W  = 3;
   localparam int EMPH_W = 5;
   localparam int EQ_W   = 4;
   localparam int DCG_W  = 3;
   localparam int DB_W   = 4;
   localparam int MODE_W = 4;
   localparam int ADDR_W = 6;
   localparam int WORD_W = 16;

   // ****************************************
   // mode select codes
   // ****************************************
   localparam logic [MODE_W-1:0] MODE_ANALOG   = 4'h0;
   localparam logic [MODE_W-1:0] MODE_RATE_DIV = 4'h3;
   localparam logic [MODE_W-1:0] MODE_PLL      = 4'h4;
   localparam logic [MODE_W-1:0] MODE_CH_PLL   = 4'h5;
   localparam logic [MODE_W-1:0] MODE_CH_SEL   = 4'h6;
   localparam logic [MODE_W-1:0] MODE_CLK_UNIT = 4'h7;
   localparam logic [MODE_W-1:0] MODE_AEQ_CONT = 4'h8;
   localparam logic [MODE_W-1:0] MODE_AEQ_ONCE = 4'h9;
   localparam logic [MODE_W-1:0] MODE_AEQ_PDN  = 4'ha;

   // ****************************************
   // encodings and timing
   // ****************************************
   localparam logic [EMPH_W-1:0] EMPH_MID     = 5'h10;
   localparam logic [EMPH_W-1:0] EMPH_ZERO    = 5'h00;
   localparam logic [DCG_W-1:0]  DCG_MAX_CODE = 3'h4;
   localparam logic [DB_W-1:0]   DCG_STEP_DB  = 4'h3;
   localparam logic [1:0]        ERR_CYCLES   = 2'h2;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic [VOD_W-1:0]  vod;
      logic [EMPH_W-1:0] pre0;
      logic [EMPH_W-1:0] pre1;
      logic [EMPH_W-1:0] pre2;
      logic [EQ_W-1:0]   eq;
      logic [DCG_W-1:0]  dcg;
   } trpc_ch_set_t;

   localparam int SET_W = $bits(trpc_ch_set_t);
   localparam trpc_ch_set_t SET_RST = '0;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_WRITE = 3'b001,
      ST_RD    = 3'b010,
      ST_RDCAP = 3'b011,
      ST_CFG   = 3'b100,
      ST_ERR   = 3'b101
   } trpc_state_t;

endpackage

// [trpc_set_mem.sv]
`timescale 1ns/1ns
module trpc_set_mem #(
   parameter int W     = 25,
   parameter int DEPTH = 4,
   parameter int AW    = 2
) (
   // clock and reset
   input  wire logic          clock_in,
   input  wire logic          nrst_in,
   // write side
   input  wire logic          we_in,
   input  wire logic [AW-1:0] waddr_in,
   input  wire logic [W-1:0]  wdata_in,
   // read side
   input  wire logic [AW-1:0] raddr_in,
   output logic      [W-1:0]  rdata_out
);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [W-1:0]            rd;
   } trpc_mem_state_t;

   trpc_mem_state_t s_r;
   trpc_mem_state_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (we_in) begin
         s_nxt.mem[waddr_in] = wdata_in;
      end
      // registered read sees the old word on a same-address write
      s_nxt.rd = s_r.mem[raddr_in];
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata_out = s_r.rd;

endmodule

// [trpc_addr_ctr.sv]
`timescale 1ns/1ns
module trpc_addr_ctr (
   // clock and reset
   input  wire logic                        clock_in,
   input  wire logic                        nrst_in,
   // control
   input  wire logic                        start_in,
   input  wire logic                        step_in,
   input  wire logic                        clear_in,
   input  wire logic [trpc_pkg::ADDR_W-1:0] last_in,
   // status
   output logic      [trpc_pkg::ADDR_W-1:0] addr_out,
   output logic                             changed_out,
   output logic                             done_out
);

   typedef struct packed {
      logic [trpc_pkg::ADDR_W-1:0] addr;
      logic                        chg;
      logic                        done;
   } trpc_ctr_state_t;

   trpc_ctr_state_t s_r;
   trpc_ctr_state_t s_nxt;

   always_comb begin
      s_nxt     = s_r;
      s_nxt.chg = 1'b0;
      if (start_in) begin
         s_nxt.done = 1'b0;
      end
      if (clear_in) begin
         s_nxt.addr = '0;
      end else if (step_in) begin
         s_nxt.chg = 1'b1;
         if (s_r.addr == last_in) begin
            // wrap to zero marks the end of the file
            s_nxt.addr = '0;
            s_nxt.done = 1'b1;
         end else begin
            s_nxt.addr = s_r.addr + 6'h01;
         end
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign addr_out    = s_r.addr;
   assign changed_out = s_r.chg;
   assign done_out    = s_r.done;

endmodule

// [trpc_port_ctrl.sv]
`timescale 1ns/1ns
// Function
// - write second post-tap 5-bit emphasis to transmitter
// - shared input copy or one per channel
// - emphasis codes 0,16 zero; signed around 16
// - write 4-bit receive equalization per channel
// - read back output swing, 3 bits per channel
// - read back three emphasis taps, 5 bits each
// - read back equalization and dc gain per channel
// - decode the 3-bit mode select codes
// - adaptive equalization widens select to 4 bits
// - fixed single mode without a mode select
// - word address counts up then wraps to zero
// - wrap to zero marks end of file
// - address change pulse after each word write unless an address reset lands in the same cycle
// - address reset pulse clears word address
// - address logic only in channel/pll modes
// - emphasis drives positive and inverted paths
// - busy high during analog read or write
module trpc_port_ctrl #(
   parameter int                           NUM_CH       = 4,
   parameter bit                           SHARED       = 1'b0,
   parameter bit                           MULTI_MODE   = 1'b1,
   parameter bit                           AEQ_EN       = 1'b0,
   parameter logic [trpc_pkg::MODE_W-1:0]  DEFAULT_MODE = trpc_pkg::MODE_ANALOG,
   parameter int                           IN_CH        = SHARED ? 1 : NUM_CH,
   parameter int                           CHW          = (NUM_CH > 1) ? $clog2(NUM_CH) : 1
) (
   // clock and reset
   input  wire logic                                            clock_in,
   input  wire logic                                            nrst_in,
   // user requests
   input  wire logic                                            write_in,
   input  wire logic                                            read_in,
   input  wire logic [trpc_pkg::MODE_W-1:0]                     mode_sel_in,
   // analog settings
   input  wire logic [IN_CH-1:0][trpc_pkg::VOD_W-1:0]           vod_in,
   input  wire logic [IN_CH-1:0][trpc_pkg::EMPH_W-1:0]          pre_tap_emphasis_in,
   input  wire logic [IN_CH-1:0][trpc_pkg::EMPH_W-1:0]          first_post_tap_emphasis_in,
   input  wire logic [IN_CH-1:0][trpc_pkg::EMPH_W-1:0]          second_post_tap_emphasis_in,
   input  wire logic [IN_CH-1:0][trpc_pkg::EQ_W-1:0]            eq_in,
   input  wire logic [IN_CH-1:0][trpc_pkg::DCG_W-1:0]           dcgain_in,
   // configuration file
   input  wire logic [trpc_pkg::WORD_W-1:0]                     cfg_data_in,
   input  wire logic [trpc_pkg::ADDR_W-1:0]                     cfg_last_addr_in,
   input  wire logic                                            addr_reset_in,
   // status
   output logic                                                 busy_out,
   output logic                                                 data_valid_out,
   output logic                                                 error_out,
   // read-back
   output logic      [NUM_CH-1:0][trpc_pkg::VOD_W-1:0]          vod_readback_out,
   output logic      [NUM_CH-1:0][trpc_pkg::EMPH_W-1:0]         pre_tap_emphasis_readback_out,
   output logic      [NUM_CH-1:0][trpc_pkg::EMPH_W-1:0]         first_post_tap_readback_out,
   output logic      [NUM_CH-1:0][trpc_pkg::EMPH_W-1:0]         second_post_tap_readback_out,
   output logic      [NUM_CH-1:0][trpc_pkg::EQ_W-1:0]           eq_readback_out,
   output logic      [NUM_CH-1:0][trpc_pkg::DCG_W-1:0]          dcgain_readback_out,
   // word address
   output logic      [trpc_pkg::ADDR_W-1:0]                     cfg_addr_out,
   output logic                                                 cfg_addr_change_out,
   output logic                                                 cfg_done_out,
   // transceiver side
   output logic                                                 pma_we_out,
   output logic      [CHW-1:0]                                  pma_ch_out,
   output trpc_pkg::trpc_ch_set_t                               pma_set_out,
   output logic signed [trpc_pkg::EMPH_W-1:0]                   pma_pre2_level_out,
   output logic signed [trpc_pkg::EMPH_W-1:0]                   pma_pre2_level_inv_out,
   output logic      [trpc_pkg::DB_W-1:0]                       pma_dcgain_db_out,
   output logic                                                 cfg_we_out,
   output logic      [trpc_pkg::WORD_W-1:0]                     cfg_word_out
);

   // ****************************************
   // decode helpers
   // ****************************************
   function automatic logic signed [trpc_pkg::EMPH_W-1:0] emph_level(
      input logic [trpc_pkg::EMPH_W-1:0] code
   );
      logic [trpc_pkg::EMPH_W-1:0] d;
      d = code - trpc_pkg::EMPH_MID;
      // code 0 is a second spelling of zero
      if (code == trpc_pkg::EMPH_ZERO) begin
         d = trpc_pkg::EMPH_ZERO;
      end
      return $signed(d);
   endfunction

   function automatic logic dcg_ok(input logic [trpc_pkg::DCG_W-1:0] code);
      return code <= trpc_pkg::DCG_MAX_CODE;
   endfunction

   function automatic logic [trpc_pkg::DB_W-1:0] dcg_db(
      input logic [trpc_pkg::DCG_W-1:0] code
   );
      logic [trpc_pkg::DB_W-1:0] db;
      db = '0;
      if (dcg_ok(code)) begin
         db = 4'(code * trpc_pkg::DCG_STEP_DB);
      end
      return db;
   endfunction

   function automatic logic mode_ok(input logic [trpc_pkg::MODE_W-1:0] m);
      logic ok;
      case (m)
         trpc_pkg::MODE_ANALOG,
         trpc_pkg::MODE_RATE_DIV,
         trpc_pkg::MODE_PLL,
         trpc_pkg::MODE_CH_PLL,
         trpc_pkg::MODE_CH_SEL,
         trpc_pkg::MODE_CLK_UNIT: begin
            ok = 1'b1;
         end
         trpc_pkg::MODE_AEQ_CONT,
         trpc_pkg::MODE_AEQ_ONCE,
         trpc_pkg::MODE_AEQ_PDN: begin
            ok = AEQ_EN;
         end
         default: begin
            ok = 1'b0;
         end
      endcase
      return ok;
   endfunction

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      trpc_pkg::trpc_state_t                    st;
      logic [CHW-1:0]                           ch;
      logic [1:0]                               err_cnt;
      logic                                     vld;
      logic                                     pma_we;
      logic [CHW-1:0]                           pma_ch;
      trpc_pkg::trpc_ch_set_t                   pma_set;
      logic signed [trpc_pkg::EMPH_W-1:0]       pre2_lvl;
      logic signed [trpc_pkg::EMPH_W-1:0]       pre2_inv;
      logic [trpc_pkg::DB_W-1:0]                dcg_db;
      logic                                     cfg_we;
      logic [trpc_pkg::WORD_W-1:0]              cfg_word;
      logic [NUM_CH-1:0][trpc_pkg::SET_W-1:0]   rb;
   } trpc_top_state_t;

   trpc_top_state_t        s_r;
   trpc_top_state_t        s_nxt;
   trpc_pkg::trpc_ch_set_t in_set;
   trpc_pkg::trpc_ch_set_t mem_rd;
   logic [trpc_pkg::MODE_W-1:0] mode;
   logic                   cfg_mode;
   logic                   gain_bad;
   logic                   mem_we;
   logic                   start_cfg;
   logic                   addr_clr;
   logic [CHW-1:0]         lane;
   logic [CHW-1:0]         last_ch;

   assign last_ch = CHW'(NUM_CH - 1);

   // ****************************************
   // mode and input selection
   // ****************************************
   always_comb begin
      // without the select the block sits in its one mode for good
      mode = MULTI_MODE ? mode_sel_in : DEFAULT_MODE;
      if (!AEQ_EN) begin
         mode[3] = 1'b0;
      end
      cfg_mode = (mode == trpc_pkg::MODE_PLL)
              || (mode == trpc_pkg::MODE_CH_PLL)
              || (mode == trpc_pkg::MODE_CH_SEL);
      gain_bad = 1'b0;
      for (int i = 0; i < IN_CH; i++) begin
         if (!dcg_ok(dcgain_in[i])) begin
            gain_bad = 1'b1;
         end
      end
      lane = SHARED ? '0 : s_r.ch;
      in_set.vod  = vod_in[lane];
      in_set.pre0 = pre_tap_emphasis_in[lane];
      in_set.pre1 = first_post_tap_emphasis_in[lane];
      in_set.pre2 = second_post_tap_emphasis_in[lane];
      in_set.eq   = eq_in[lane];
      in_set.dcg  = dcgain_in[lane];
   end

   // ****************************************
   // transaction sequencer
   // ****************************************
   always_comb begin
      s_nxt        = s_r;
      s_nxt.pma_we = 1'b0;
      s_nxt.cfg_we = 1'b0;
      mem_we       = 1'b0;
      start_cfg    = 1'b0;
      case (s_r.st)
         trpc_pkg::ST_IDLE: begin
            s_nxt.ch = '0;
            // a request is a single-cycle pulse; a held level restarts
            if (write_in || read_in) begin
               s_nxt.vld = 1'b0;
               if (!mode_ok(mode)) begin
                  s_nxt.st      = trpc_pkg::ST_ERR;
                  s_nxt.err_cnt = trpc_pkg::ERR_CYCLES;
               end else if (mode == trpc_pkg::MODE_ANALOG) begin
                  if (write_in && gain_bad) begin
                     s_nxt.st      = trpc_pkg::ST_ERR;
                     s_nxt.err_cnt = trpc_pkg::ERR_CYCLES;
                  end else if (write_in) begin
                     s_nxt.st = trpc_pkg::ST_WRITE;
                  end else begin
                     s_nxt.st = trpc_pkg::ST_RD;
                  end
               end else if (read_in) begin
                  // only analog settings can be read back
                  s_nxt.st      = trpc_pkg::ST_ERR;
                  s_nxt.err_cnt = trpc_pkg::ERR_CYCLES;
               end else if (cfg_mode) begin
                  s_nxt.st  = trpc_pkg::ST_CFG;
                  start_cfg = 1'b1;
               end
            end
         end
         trpc_pkg::ST_WRITE: begin
            mem_we         = 1'b1;
            s_nxt.pma_we   = 1'b1;
            s_nxt.pma_ch   = s_r.ch;
            s_nxt.pma_set  = in_set;
            // one setting feeds both polarities of the tap
            s_nxt.pre2_lvl = emph_level(in_set.pre2);
            s_nxt.pre2_inv = -emph_level(in_set.pre2);
            s_nxt.dcg_db   = dcg_db(in_set.dcg);
            if (s_r.ch == last_ch) begin
               s_nxt.st = trpc_pkg::ST_IDLE;
            end else begin
               s_nxt.ch = s_r.ch + 1'b1;
            end
         end
         trpc_pkg::ST_RD: begin
            s_nxt.st = trpc_pkg::ST_RDCAP;
         end
         trpc_pkg::ST_RDCAP: begin
            s_nxt.rb[s_r.ch] = mem_rd;
            if (s_r.ch == last_ch) begin
               s_nxt.st  = trpc_pkg::ST_IDLE;
               s_nxt.vld = 1'b1;
            end else begin
               s_nxt.ch = s_r.ch + 1'b1;
               s_nxt.st = trpc_pkg::ST_RD;
            end
         end
         trpc_pkg::ST_CFG: begin
            s_nxt.cfg_we   = 1'b1;
            s_nxt.cfg_word = cfg_data_in;
            s_nxt.st       = trpc_pkg::ST_IDLE;
         end
         trpc_pkg::ST_ERR: begin
            s_nxt.err_cnt = s_r.err_cnt - 2'h1;
            if (s_r.err_cnt == 2'h1) begin
               s_nxt.st = trpc_pkg::ST_IDLE;
            end
         end
         default: begin
            s_nxt.st = trpc_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_r    <= '0;
         s_r.st <= trpc_pkg::ST_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ****************************************
   // settings store and word address
   // ****************************************
   trpc_set_mem #(
      .W     (trpc_pkg::SET_W),
      .DEPTH (NUM_CH),
      .AW    (CHW)
   ) u_mem (
      .clock_in  (clock_in),
      .nrst_in   (nrst_in),
      .we_in     (mem_we),
      .waddr_in  (s_r.ch),
      .wdata_in  (in_set),
      .raddr_in  (s_r.ch),
      .rdata_out (mem_rd)
   );

   // address reset only counts in the file-based modes
   assign addr_clr = addr_reset_in && cfg_mode;

   trpc_addr_ctr u_addr (
      .clock_in    (clock_in),
      .nrst_in     (nrst_in),
      .start_in    (start_cfg),
      .step_in     (s_r.cfg_we),
      .clear_in    (addr_clr),
      .last_in     (cfg_last_addr_in),
      .addr_out    (cfg_addr_out),
      .changed_out (cfg_addr_change_out),
      .done_out    (cfg_done_out)
   );

   // ****************************************
   // outputs
   // ****************************************
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         vod_readback_out[i]              = s_r.rb[i][24:22];
         pre_tap_emphasis_readback_out[i] = s_r.rb[i][21:17];
         first_post_tap_readback_out[i]   = s_r.rb[i][16:12];
         second_post_tap_readback_out[i]  = s_r.rb[i][11:7];
         eq_readback_out[i]               = s_r.rb[i][6:3];
         dcgain_readback_out[i]           = s_r.rb[i][2:0];
      end
   end

   // busy drops during the error window
   assign busy_out = (s_r.st != trpc_pkg::ST_IDLE)
                  && (s_r.st != trpc_pkg::ST_ERR);
   assign error_out              = (s_r.st == trpc_pkg::ST_ERR);
   assign data_valid_out         = s_r.vld;
   assign pma_we_out             = s_r.pma_we;
   assign pma_ch_out             = s_r.pma_ch;
   assign pma_set_out            = s_r.pma_set;
   assign pma_pre2_level_out     = s_r.pre2_lvl;
   assign pma_pre2_level_inv_out = s_r.pre2_inv;
   assign pma_dcgain_db_out      = s_r.dcg_db;
   assign cfg_we_out             = s_r.cfg_we;
   assign cfg_word_out           = s_r.cfg_word;

endmodule

// [trpc_port_ctrl_properties.sv]
`timescale 1ns/1ns
module trpc_port_ctrl_properties #(
   parameter int NUM_CH = 4,
   parameter int IN_CH  = 4
) (
   // clock and reset
   input wire logic                   clock_in,
   input wire logic                   nrst_in,
   // user side
   input wire logic                   write_in,
   input wire logic                   read_in,
   input wire logic [3:0]             mode_sel_in,
   input wire logic [IN_CH-1:0][2:0]  dcgain_in,
   input wire logic [5:0]             cfg_last_addr_in,
   input wire logic                   addr_reset_in,
   // status
   input wire logic                   busy_out,
   input wire logic                   data_valid_out,
   input wire logic                   error_out,
   input wire logic [5:0]             cfg_addr_out,
   input wire logic                   cfg_addr_change_out,
   input wire logic                   cfg_done_out,
   input wire logic                   cfg_we_out,
   // transceiver side
   input wire logic                   pma_we_out,
   input wire trpc_pkg::trpc_ch_set_t pma_set_out,
   input wire logic signed [4:0]      pma_pre2_level_out,
   input wire logic signed [4:0]      pma_pre2_level_inv_out,
   input wire logic [3:0]             pma_dcgain_db_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!nrst_in);

   wire  idle     = !busy_out && !error_out;
   // bit 3 is ignored: no adaptive support built
   wire  bad_mode = mode_sel_in[2:0] inside {3'h1, 3'h2};
   logic dcg_ok;
   always_comb begin
      dcg_ok = 1'b1;
      for (int i = 0; i < IN_CH; i++) begin
         if (dcgain_in[i] > 3'h4) dcg_ok = 1'b0;
      end
   end

   sequence take_wr;
      idle && write_in;
   endsequence
   sequence step_s;
      cfg_we_out && !addr_reset_in;
   endsequence

   // ****************************************
   // assertions
   // ****************************************
   inv_path_a: assert property (pma_we_out |-> pma_pre2_level_inv_out == -pma_pre2_level_out)
      else $error("inverted tap level wrong");
   emph_map_a: assert property (pma_we_out |-> pma_pre2_level_out == ((pma_set_out.pre2 inside {5'h00, 5'h10}) ?
      5'sh00 : $signed(pma_set_out.pre2 - 5'h10))) else $error("tap level decode wrong");
   gain_db_a: assert property (pma_we_out |-> pma_dcgain_db_out == {1'b0, pma_set_out.dcg} * 4'h3)
      else $error("dc gain in dB wrong");
   refuse_mode_a: assert property (take_wr and bad_mode |=> (error_out && !busy_out)[*2] ##1 !error_out)
      else $error("bad mode not refused");
   refuse_gain_a: assert property (take_wr and mode_sel_in == 4'h0 && !dcg_ok |=> error_out && !pma_we_out)
      else $error("bad gain not refused");
   write_busy_a: assert property (take_wr and mode_sel_in == 4'h0 && dcg_ok |=> busy_out[*4] ##1 !busy_out)
      else $error("write busy span wrong");
   read_busy_a: assert property (idle && read_in && !write_in && mode_sel_in == 4'h0
      |=> busy_out[*8] ##1 (!busy_out && data_valid_out)) else $error("read busy span wrong");
   addr_step_a: assert property (step_s |=> cfg_addr_change_out && cfg_addr_out ==
      (($past(cfg_addr_out) == cfg_last_addr_in) ? 6'h00 : $past(cfg_addr_out) + 6'h01)) else $error("step wrong");
   wrap_done_a: assert property (step_s and cfg_addr_out == cfg_last_addr_in
      |=> cfg_addr_out == 6'h00 && cfg_done_out) else $error("wrap without done");
   addr_clear_a: assert property (addr_reset_in && mode_sel_in inside {4'h4, 4'h5, 4'h6}
      |=> cfg_addr_out == 6'h00 && !cfg_addr_change_out) else $error("address not cleared");
   addr_hold_a: assert property (addr_reset_in && mode_sel_in == 4'h0 && !cfg_we_out |=> $stable(cfg_addr_out))
      else $error("address reset outside cfg modes");
endmodule

bind trpc_port_ctrl trpc_port_ctrl_properties #(.NUM_CH(NUM_CH), .IN_CH(IN_CH)) trpc_port_ctrl_properties_i (.*);

// [trpc_user_model.sv]
`timescale 1ns/1ns
module trpc_user_model (
   // clock and reset
   input  wire logic clock_in,
   input  wire logic nrst_in,
   // commands, levels
   input  wire logic wr_in,
   input  wire logic rd_in,
   // requests
   output logic      write_out,
   output logic      read_out
);
   logic wr_r;
   logic rd_r;
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         {wr_r, rd_r, write_out, read_out} <= '0;
      end else begin
         {wr_r, rd_r} <= {wr_in, rd_in};
         write_out    <= wr_in && !wr_r;
         read_out     <= rd_in && !rd_r;
      end
   end
endmodule

// [trpc_port_ctrl_bench.sv]
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
   $display("wrong value at %0t: %h %h", $time, a, b); end end
module trpc_port_ctrl_bench;
   logic                   clock_in, nrst_in, write_in, read_in, addr_reset_in, wr, rd, dv_q, er_q, e, eq[$];
   logic [3:0]             mode_sel_in;
   logic [3:0][2:0]        vod_in, dcgain_in, vod_readback_out, dcgain_readback_out;
   logic [3:0][4:0]        pre_tap_emphasis_in, first_post_tap_emphasis_in, second_post_tap_emphasis_in;
   logic [3:0][4:0]        pre_tap_emphasis_readback_out, first_post_tap_readback_out, second_post_tap_readback_out;
   logic [3:0][3:0]        eq_in, eq_readback_out;
   logic [15:0]            cfg_data_in, cfg_word_out, w, cq[$];
   logic [5:0]             cfg_last_addr_in, cfg_addr_out;
   logic                   busy_out, data_valid_out, error_out, cfg_addr_change_out, cfg_done_out;
   logic                   pma_we_out, cfg_we_out;
   logic [1:0]             pma_ch_out;
   logic signed [4:0]      pma_pre2_level_out, pma_pre2_level_inv_out;
   logic [3:0]             pma_dcgain_db_out;
   logic [6:0]             a, aq[$];
   trpc_pkg::trpc_ch_set_t pma_set_out, x, y, last[4], wq[$], rq[$];
   int                     error_cnt = 0, comparisons = 0, seed = 32'h7d884f58, ea;
   localparam logic [4:0]  EDGE[4] = '{5'h00, 5'h10, 5'h01, 5'h1f};
   localparam logic [3:0]  BAD[4]  = '{4'h1, 4'h2, 4'h9, 4'ha};

   trpc_port_ctrl trpc_port_ctrl_i (.*);
   trpc_user_model trpc_user_model_i (.clock_in, .nrst_in, .wr_in(wr), .rd_in(rd), .write_out(write_in),
      .read_out(read_in));

   initial begin
      clock_in = 1'b0;
      forever #4 clock_in = ~clock_in;
   end

   function automatic logic signed [4:0] lvl(logic [4:0] c);
      return (c == 5'h00 || c == 5'h10) ? 5'sh00 : $signed(c - 5'h10);
   endfunction

   task automatic conclude();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic put(int i, trpc_pkg::trpc_ch_set_t s);
      {vod_in[i], pre_tap_emphasis_in[i], first_post_tap_emphasis_in[i], second_post_tap_emphasis_in[i],
         eq_in[i], dcgain_in[i]} = s;
   endtask

   task automatic req(bit wv, bit rv, logic [3:0] m);
      mode_sel_in = m;
      wr = wv;
      rd = rv;
      repeat (2) @(posedge clock_in);
      #1;
      {wr, rd} = 2'b00;
      while (busy_out !== 1'b0 || error_out !== 1'b0) begin
         @(posedge clock_in);
         #1;
      end
      repeat (3) @(posedge clock_in);
      #1;
   endtask

   task automatic wr_all(int j);
      trpc_pkg::trpc_ch_set_t s;
      for (int i = 0; i < 4; i++) begin
         s = 25'($random(seed));
         s.dcg = (j == 0) ? 3'h4 : 3'($unsigned($random(seed)) % 5);
         if (j == 0) s.pre2 = EDGE[i];
         put(i, s);
         wq.push_back(s);
         last[i] = s;
      end
      req(1'b1, 1'b0, 4'h0);
   endtask

   task automatic rd_all();
      for (int i = 0; i < 4; i++) rq.push_back(last[i]);
      req(1'b0, 1'b1, 4'h0);
   endtask

   task automatic clr(logic [3:0] m);
      mode_sel_in = m;
      addr_reset_in = 1'b1;
      @(posedge clock_in);
      #1;
      addr_reset_in = 1'b0;
      @(posedge clock_in);
      #1;
   endtask

   task automatic cfg_wr(logic [3:0] m);
      cfg_data_in = 16'($random(seed));
      cq.push_back(cfg_data_in);
      ea = (ea == 2) ? 0 : ea + 1;
      aq.push_back({ea == 0, 6'(ea)});
      req(1'b1, 1'b0, m);
   endtask

   always @(posedge clock_in) begin
      dv_q <= data_valid_out;
      er_q <= error_out;
      if (pma_we_out === 1'b1) begin
         x = wq.size() ? wq.pop_front() : 'x;
         `CHK(pma_ch_out, 2'(3 - wq.size()))
         `CHK(pma_set_out, x)
         `CHK(pma_pre2_level_out, lvl(x.pre2))
         `CHK(pma_pre2_level_inv_out, -lvl(x.pre2))
         `CHK(pma_dcgain_db_out, {1'b0, x.dcg} * 4'h3)
      end
      if (data_valid_out === 1'b1 && dv_q === 1'b0) begin
         for (int i = 0; i < 4; i++) begin
            x = rq.size() ? rq.pop_front() : 'x;
            y = {vod_readback_out[i], pre_tap_emphasis_readback_out[i], first_post_tap_readback_out[i],
               second_post_tap_readback_out[i], eq_readback_out[i], dcgain_readback_out[i]};
            `CHK(y, x)
         end
      end
      if (error_out === 1'b1 && er_q === 1'b0) begin
         e = eq.size() ? eq.pop_front() : 1'bx;
         `CHK(e, 1'b1)
         `CHK(busy_out, 1'b0)
      end
      if (cfg_we_out === 1'b1) begin
         w = cq.size() ? cq.pop_front() : 'x;
         `CHK(cfg_word_out, w)
      end
      if (cfg_addr_change_out === 1'b1) begin
         a = aq.size() ? aq.pop_front() : 'x;
         `CHK({cfg_done_out, cfg_addr_out}, a)
      end
   end

   initial begin
      #100000;
      error_cnt++;
      conclude();
   end

   initial begin
      trpc_pkg::trpc_ch_set_t s;
      {nrst_in, wr, rd, addr_reset_in, mode_sel_in, cfg_data_in} = '0;
      {vod_in, pre_tap_emphasis_in, first_post_tap_emphasis_in, second_post_tap_emphasis_in, eq_in, dcgain_in} = '0;
      cfg_last_addr_in = 6'h02;
      ea = 0;
      repeat (2) @(posedge clock_in);
      #1;
      nrst_in = 1'b1;
      for (int j = 0; j < 4; j++) wr_all(j);
      rd_all();
      s = last[2];
      s.dcg = 3'h5;
      put(2, s);
      eq.push_back(1'b1);
      req(1'b1, 1'b0, 4'h0);
      put(2, last[2]);
      foreach (BAD[k]) begin
         eq.push_back(1'b1);
         req(1'b1, 1'b0, BAD[k]);
      end
      eq.push_back(1'b1);
      req(1'b0, 1'b1, 4'h4);
      second_post_tap_emphasis_in = '0;
      req(1'b1, 1'b0, 4'hb);
      req(1'b1, 1'b0, 4'hf);
      rd_all();
      for (int k = 0; k < 4; k++) cfg_wr(4'h4 + 4'(k % 3));
      clr(4'h5);
      `CHK(cfg_addr_out, 6'h00)
      ea = 0;
      cfg_wr(4'h6);
      clr(4'h0);
      `CHK(cfg_addr_out, 6'h01)
      `CHK(wq.size() + rq.size() + cq.size() + aq.size() + eq.size(), 0)
      conclude();
   end
endmodule
